// File: pwmtg_pkg.sv
package pwmtg_pkg;
   localparam logic [7:0] PWMTG_ADDR_CONTROL = 8'ha1;
   localparam logic [7:0] PWMTG_ADDR_VALUE_LOW = 8'ha2;
   localparam logic [7:0] PWMTG_ADDR_VALUE_HIGH = 8'ha3;
   localparam logic [7:0] PWMTG_CONTROL_RESET = 8'h00;
   localparam logic [15:0] PWMTG_VALUE_RESET = 16'h0000;
   localparam int PWMTG_START_LEVEL_BIT = 5;
   localparam int PWMTG_VALUE_SEL_BIT = 4;
   localparam int PWMTG_CLK_SEL_BIT = 3;
   localparam int PWMTG_MODE_LSB = 0;
   localparam logic [2:0] PWMTG_MODE_OFF = 3'h0;
   localparam logic [2:0] PWMTG_MODE_PWM = 3'h1;
   localparam logic [2:0] PWMTG_MODE_SQUARE = 3'h3;
   localparam logic [2:0] PWMTG_MODE_STAIR = 3'h7;
   localparam logic [1:0] PWMTG_QUARTER_SHIFT = 2'h2;

   typedef struct packed {
      logic [1:0] unused;
      logic start_level_select;
      logic value_register_select;
      logic count_clock_select;
      logic [2:0] generator_mode;
   } pwmtg_ctrl_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pwmtg_sfr_req_t;
endpackage

// File: pwmtg_top.sv
`timescale 1ns/1ns
// Contract
// - start level bit 0: duty is ON time first; 1: duty is OFF time first
// - value select bit 0 reaches period value, 1 reaches duty value
// - count clock select 0 counts microsecond tick, 1 counts system clock
// - mode 000 off, 001 pwm, 011 square tone, 111 staircase tone
// - low byte location reads and writes low eight bits of selected value
// - high byte location reads and writes high eight bits of selected value
// - in tone modes the value is the half-period divisor in ticks
// - staircase tone releases the output for the last quarter of each half-period
module pwmtg_top
   import pwmtg_pkg::*;
#(
   parameter int VALUE_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pwmtg_sfr_req_t sfr_req_i,
   input wire logic microsecond_tick_i,
   output logic [7:0] sfr_rdata_o,
   output logic wave_o,
   output logic wave_oe_o
);
   // the counter, limits and byte split are all built for a 16-bit value
   if (VALUE_W != 16) begin : g_value_w_check
      $error("pwmtg_top: value width must be 16");
   end

   pwmtg_ctrl_t ctrl_r, ctrl_nxt;
   logic [15:0] period_r, period_nxt;
   logic [15:0] duty_r, duty_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic wave_r, wave_nxt;
   logic oe_r, oe_nxt;
   logic [7:0] rdata_r, rdata_nxt;

   wire [2:0] mode = ctrl_r.generator_mode;
   wire is_pwm = (mode == PWMTG_MODE_PWM);
   wire is_square = (mode == PWMTG_MODE_SQUARE);
   wire is_stair = (mode == PWMTG_MODE_STAIR);
   wire is_tone = is_square | is_stair;
   // undefined mode codes behave as disabled
   wire active = is_pwm | is_tone;
   wire tick = ctrl_r.count_clock_select ? 1'b1 : microsecond_tick_i;
   wire [15:0] sel_value = ctrl_r.value_register_select ? duty_r : period_r;
   wire [15:0] limit = period_r; // period in pwm, divisor in tone
   wire [16:0] cnt_inc = {1'b0, cnt_r} + 17'h00001;
   wire wrap = cnt_inc >= {1'b0, limit};
   wire on_level = ~ctrl_r.start_level_select;
   wire [15:0] quarter_start = limit - (limit >> PWMTG_QUARTER_SHIFT);
   wire hit_low = sfr_req_i.addr == PWMTG_ADDR_VALUE_LOW;
   wire hit_high = sfr_req_i.addr == PWMTG_ADDR_VALUE_HIGH;
   wire hit_ctrl = sfr_req_i.addr == PWMTG_ADDR_CONTROL;
   wire wr_sel_duty = ctrl_r.value_register_select;

   always_comb begin
      ctrl_nxt = ctrl_r;
      period_nxt = period_r;
      duty_nxt = duty_r;
      if (sfr_req_i.wr) begin
         if (hit_ctrl) begin
            ctrl_nxt = pwmtg_ctrl_t'({2'b00, sfr_req_i.wdata[5:0]});
         end
         if (hit_low && !wr_sel_duty) period_nxt[7:0] = sfr_req_i.wdata;
         if (hit_low && wr_sel_duty) duty_nxt[7:0] = sfr_req_i.wdata;
         if (hit_high && !wr_sel_duty) period_nxt[15:8] = sfr_req_i.wdata;
         if (hit_high && wr_sel_duty) duty_nxt[15:8] = sfr_req_i.wdata;
      end
   end

   // reads of unmapped addresses return zero; reserved control bits read zero
   assign rdata_nxt = !sfr_req_i.rd ? rdata_r :
                      hit_ctrl ? {2'b00, ctrl_r[5:0]} :
                      hit_low ? sel_value[7:0] :
                      hit_high ? sel_value[15:8] : 8'h00;

   // counter restarts whenever the generator is off, so a new mode begins cleanly
   assign cnt_nxt = !active ? 16'h0000 :
                    !tick ? cnt_r :
                    wrap ? 16'h0000 : cnt_inc[15:0];

   always_comb begin
      wave_nxt = 1'b0;
      oe_nxt = 1'b0;
      if (is_pwm) begin
         oe_nxt = 1'b1;
         wave_nxt = (cnt_nxt < duty_r) ? on_level : ~on_level;
      end else if (is_tone) begin
         wave_nxt = (tick && wrap) ? ~wave_r : wave_r;
         oe_nxt = is_square | (cnt_nxt < quarter_start);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_r <= pwmtg_ctrl_t'(PWMTG_CONTROL_RESET);
         period_r <= PWMTG_VALUE_RESET;
         duty_r <= PWMTG_VALUE_RESET;
         cnt_r <= 16'h0000;
         wave_r <= 1'b0;
         oe_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         ctrl_r <= ctrl_nxt;
         period_r <= period_nxt;
         duty_r <= duty_nxt;
         cnt_r <= cnt_nxt;
         wave_r <= wave_nxt;
         oe_r <= oe_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign sfr_rdata_o = rdata_r;
   assign wave_o = wave_r;
   assign wave_oe_o = oe_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_pwm_level;
      (is_pwm && $past(is_pwm) && $stable(ctrl_r) && $stable(duty_r))
         |-> (wave_r == ((cnt_r < duty_r) ? ~ctrl_r.start_level_select : ctrl_r.start_level_select));
   endproperty
   a_pwm_level: assert property (p_pwm_level) else $error("pwm level wrong for count");

   property p_write_low;
      (sfr_req_i.wr && hit_low && !ctrl_r.value_register_select)
         |=> (period_r[7:0] == $past(sfr_req_i.wdata)) && $stable(duty_r);
   endproperty
   a_write_low: assert property (p_write_low) else $error("low byte write missed period");

   property p_write_high_duty;
      (sfr_req_i.wr && hit_high && ctrl_r.value_register_select)
         |=> (duty_r[15:8] == $past(sfr_req_i.wdata)) && $stable(period_r);
   endproperty
   a_write_high_duty: assert property (p_write_high_duty) else $error("high byte write missed duty");

   property p_sysclk_count;
      (is_pwm && ctrl_r.count_clock_select && period_r > 16'h0002 && cnt_r == 16'h0000)
         ##1 (is_pwm && $stable(ctrl_r) && $stable(period_r)) |-> cnt_r == 16'h0001;
   endproperty
   a_sysclk_count: assert property (p_sysclk_count) else $error("system clock not counted");

   property p_microsecond_tick_hold;
      (active && !ctrl_r.count_clock_select && !microsecond_tick_i) |=> $stable(cnt_r) || !$past(active);
   endproperty
   a_microsecond_tick_hold: assert property (p_microsecond_tick_hold) else $error("count moved without tick");

   property p_disabled;
      (mode == PWMTG_MODE_OFF) |=> !wave_oe_o && !wave_o && cnt_r == 16'h0000;
   endproperty
   a_disabled: assert property (p_disabled) else $error("output active while disabled");

   property p_read_low;
      (sfr_req_i.rd && hit_low)
         |=> sfr_rdata_o == $past(ctrl_r.value_register_select ? duty_r[7:0] : period_r[7:0]);
   endproperty
   a_read_low: assert property (p_read_low) else $error("low byte read wrong");

   property p_square_toggle;
      (is_square && tick && wrap) ##1 is_square |-> wave_r != $past(wave_r);
   endproperty
   a_square_toggle: assert property (p_square_toggle) else $error("square did not toggle");

   property p_tone_bound;
      (is_tone && $past(is_tone) && $past(tick) && $stable(period_r) && period_r != 16'h0000)
         |-> cnt_r < period_r;
   endproperty
   a_tone_bound: assert property (p_tone_bound) else $error("divisor count overran");

   property p_stair_release;
      (is_stair && $past(is_stair) && $stable(period_r)) |-> (wave_oe_o == (cnt_r < quarter_start));
   endproperty
   a_stair_release: assert property (p_stair_release) else $error("staircase release wrong");

   property p_write_low_duty;
      (sfr_req_i.wr && hit_low && ctrl_r.value_register_select)
         |=> (duty_r[7:0] == $past(sfr_req_i.wdata)) && $stable(period_r);
   endproperty
   a_write_low_duty: assert property (p_write_low_duty) else $error("low byte write missed duty");

   property p_write_high_period;
      (sfr_req_i.wr && hit_high && !ctrl_r.value_register_select)
         |=> (period_r[15:8] == $past(sfr_req_i.wdata)) && $stable(duty_r);
   endproperty
   a_write_high_period: assert property (p_write_high_period) else $error("high byte missed period");

   property p_read_high;
      (sfr_req_i.rd && hit_high)
         |=> sfr_rdata_o == $past(ctrl_r.value_register_select ? duty_r[15:8] : period_r[15:8]);
   endproperty
   a_read_high: assert property (p_read_high) else $error("high byte read wrong");

   property p_read_ctrl;
      (sfr_req_i.rd && hit_ctrl) |=> sfr_rdata_o == {2'b00, $past(ctrl_r[5:0])};
   endproperty
   a_read_ctrl: assert property (p_read_ctrl) else $error("control read wrong");

   // read data must stand between reads, software may pick it up late
   property p_rdata_hold;
      !sfr_req_i.rd |=> $stable(sfr_rdata_o);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

   property p_driven_modes;
      (is_pwm || is_square) |=> wave_oe_o;
   endproperty
   a_driven_modes: assert property (p_driven_modes) else $error("output released in a driven mode");

   property p_undefined_off;
      (!active && mode != PWMTG_MODE_OFF) |=> !wave_oe_o && !wave_o && cnt_r == 16'h0000;
   endproperty
   a_undefined_off: assert property (p_undefined_off) else $error("undefined mode not disabled");

   property p_microsecond_tick_step;
      (active && !ctrl_r.count_clock_select && microsecond_tick_i && !wrap)
         |=> cnt_r == $past(cnt_r) + 16'h0001;
   endproperty
   a_microsecond_tick_step: assert property (p_microsecond_tick_step) else $error("tick not counted");

   c_pwm_wrap: cover property (is_pwm && tick && wrap && period_r > 16'h0003);
   c_square_toggle: cover property (is_square && tick && wrap);
   c_stair_release: cover property (is_stair && $fell(wave_oe_o));
   c_read_ctrl: cover property (sfr_req_i.rd && hit_ctrl);
endmodule // pwmtg_top

// File: pwmtg_load.sv
`timescale 1ns/1ns
module pwmtg_load (
   input wire logic clk_i,
   input wire logic wave_i,
   input wire logic oe_i,
   output logic pin_o
);
   logic last_r;
   always_ff @(posedge clk_i) begin
      if (oe_i) begin
         last_r <= wave_i;
      end
   end
   // no pull on the pin: a released line shows the inverse, never a stale copy
   assign pin_o = oe_i ? wave_i : ~last_r;
endmodule // pwmtg_load

// File: pwmtg_top_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module pwmtg_top_tb;
   import pwmtg_pkg::*;
   logic clk_i, rst_i, tick_i, tick_en, pin, wave, oe;
   logic [7:0] rdata;
   pwmtg_sfr_req_t req;
   int n_errors, checks_done, n_hi, n_off, n_tg;
   int tick_cnt = 0;
   pwmtg_top dut (.clk_i(clk_i), .rst_i(rst_i), .sfr_req_i(req), .microsecond_tick_i(tick_i),
      .sfr_rdata_o(rdata), .wave_o(wave), .wave_oe_o(oe));
   pwmtg_load load (.clk_i(clk_i), .wave_i(wave), .oe_i(oe), .pin_o(pin));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // tick every fifth clock instead of every 250th keeps the run short
   always @(posedge clk_i) begin
      tick_cnt <= (tick_cnt == 4) ? 0 : tick_cnt + 1;
      tick_i <= #1 tick_en && (tick_cnt == 4);
   end
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i) #1;
      req = '{wr: w, rd: ~w, addr: a, wdata: d};
      @(posedge clk_i) #1;
      req.wr = 1'b0;
      req.rd = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      access(1'b0, a, 8'h00);
      `CHK(rdata, e)
   endtask
   task automatic measure(input int n);
      logic prev;
      repeat (20) @(posedge clk_i);
      #1 prev = pin;
      n_hi = 0;
      n_off = 0;
      n_tg = 0;
      repeat (n) begin
         @(posedge clk_i) #1;
         n_hi += (pin === 1'b1);
         n_off += (oe === 1'b0);
         n_tg += (pin !== prev);
         prev = pin;
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      stop_test();
   end
   initial begin
      rst_i = 1'b1;
      req = '0;
      tick_en = 1'b0;
      repeat (20) @(posedge clk_i);
      #1 rst_i = 1'b0;
      `CHK(oe, 1'b0)
      rd(PWMTG_ADDR_CONTROL, 8'h00);
      rd(PWMTG_ADDR_VALUE_LOW, 8'h00);
      rd(PWMTG_ADDR_VALUE_HIGH, 8'h00);
      access(1'b1, PWMTG_ADDR_CONTROL, 8'hf2);
      rd(PWMTG_ADDR_CONTROL, 8'h32);
      rd(8'ha4, 8'h00);
      measure(8);
      `CHK(n_off, 8)
      access(1'b1, PWMTG_ADDR_VALUE_LOW, 8'h03);
      access(1'b1, PWMTG_ADDR_CONTROL, 8'h09);
      access(1'b1, PWMTG_ADDR_VALUE_LOW, 8'h08);
      access(1'b1, PWMTG_ADDR_VALUE_HIGH, 8'h12);
      rd(PWMTG_ADDR_VALUE_LOW, 8'h08);
      rd(PWMTG_ADDR_VALUE_HIGH, 8'h12);
      access(1'b1, PWMTG_ADDR_VALUE_HIGH, 8'h00);
      access(1'b1, PWMTG_ADDR_CONTROL, 8'h19);
      rd(PWMTG_ADDR_VALUE_LOW, 8'h03);
      measure(16);
      `CHK(n_hi, 6)
      access(1'b1, PWMTG_ADDR_CONTROL, 8'h39);
      measure(16);
      `CHK(n_hi, 10)
      tick_en = 1'b1;
      access(1'b1, PWMTG_ADDR_CONTROL, 8'h11);
      measure(40);
      `CHK(n_hi, 15)
      `CHK(n_tg, 2)
      tick_en = 1'b0;
      access(1'b1, PWMTG_ADDR_CONTROL, 8'h0b);
      access(1'b1, PWMTG_ADDR_VALUE_LOW, 8'h04);
      measure(16);
      `CHK(n_tg, 4)
      `CHK(n_off, 0)
      access(1'b1, PWMTG_ADDR_CONTROL, 8'h0f);
      measure(16);
      `CHK(n_off, 4)
      `CHK(n_hi, 8)
      stop_test();
   end
endmodule // pwmtg_top_tb
